// File: hdl/apr_addr_step.sv
/*
  Next-sector address: plus one in lba form, or sector, head, cylinder
  carry in chs form with sectors numbered from one.
  Assumes the current address lies inside the given geometry.
*/
`timescale 1ns/1ps
module apr_addr_step #(
  parameter int HEADS           = 16,
  parameter int SECTORS_PER_TRK = 63
) (
  // current address and form
  input  apr_pkg::apr_addr_s cur,
  input  logic               chs,
  // following address
  output apr_pkg::apr_addr_s nxt
);
  import apr_pkg::*;

  localparam logic [7:0] LAST_SECT = 8'(SECTORS_PER_TRK);
  localparam logic [3:0] LAST_HEAD = 4'(HEADS - 1);

  always_comb begin
    nxt = cur;
    if (!chs) begin
      nxt = apr_addr_s'(28'(cur + 28'h0000001));
    end else if (cur.sect != LAST_SECT) begin
      nxt.sect = cur.sect + 8'h01;
    end else begin
      nxt.sect = 8'h01;
      if (cur.head != LAST_HEAD) begin
        nxt.head = cur.head + 4'h1;
      end else begin
        nxt.head = 4'h0;
        nxt.cyl  = cur.cyl + 16'h0001;
      end
    end
  end

endmodule

// File: hdl/apr_defines.svh
/*
  Constants of the pio read command block: register byte offsets on the
  axi4-lite slave, opcodes, status and error bit positions, counts.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef APR_DEFINES_SVH
`define APR_DEFINES_SVH

// register byte offsets, one aligned word each
`define APR_OFS_DATA      8'h00
`define APR_OFS_ERROR     8'h04
`define APR_OFS_COUNT     8'h08
`define APR_OFS_SECTOR    8'h0C
`define APR_OFS_CYL_LO    8'h10
`define APR_OFS_CYL_HI    8'h14
`define APR_OFS_DRVHD     8'h18
`define APR_OFS_CMD       8'h1C
`define APR_OFS_BLKSZ     8'h20

// opcodes
`define APR_OP_BLOCK_READ 8'hC4
`define APR_OP_READ       8'h20
`define APR_OP_READ_NR    8'h21
`define APR_OP_NATIVE_MAX 8'hF8

// status bits
`define APR_ST_BUSY       7
`define APR_ST_RDY        6
`define APR_ST_DSC        4
`define APR_ST_DRQ        3
`define APR_ST_ERR        0

// error cause bits
`define APR_ER_UNC        6
`define APR_ER_IDN        4
`define APR_ER_ABT        2
`define APR_ER_AMN        0

// drive/head register fields
`define APR_DH_LBA        6
`define APR_DH_DRV        4
`define APR_DH_FIXED      4'hA

// counts and reset values
`define APR_ZERO_COUNT    9'h100
`define APR_WORDS_PER_SEC 256
`define APR_RETRIES       2
`define APR_BLKSZ_RESET   8'h00
`define APR_RESP_OKAY     2'b00
`define APR_RESP_SLVERR   2'b10

`endif

// File: hdl/apr_pkg.sv
/*
  Types of the pio read command block: address carrier, media request
  and answer carriers, engine states.
  Assumes nothing of its surroundings.
*/
package apr_pkg;

  // same packing serves chs (head, cylinder, sector) and 28-bit lba
  typedef struct packed {
    logic [3:0]  head;
    logic [15:0] cyl;
    logic [7:0]  sect;
  } apr_addr_s;

  typedef struct packed {
    apr_addr_s addr;
    logic      chs;
    logic      retry_dis;
  } apr_med_req_s;

  typedef struct packed {
    logic uncorrectable_cause;
    logic idnf;
    logic amnf;
  } apr_med_rsp_s;

  typedef enum {
    ST_IDLE,
    ST_WAIT,
    ST_XFER
  } apr_state_e;

endpackage

// File: hdl/apr_read_engine.sv
/*
  Task-file register set and command engine for the pio read commands
  (block-mode read, sector read with optional retry, native maximum).
  Assumes an axi4-lite master on sys_clk and a media engine on sys_clk
  that takes every request pulse, answers with one status, then on
  success offers the sector's words under valid/ready.
*/
// Summary of operation
// - opcode C4h reads sectors and delivers them
// - payload moves as one 16-bit word per access
// - block-mode read interrupts once per configured block
// - transfer count zero means 256 sectors
// - lba bits split over sector, cylinders, head
// - count left holds sectors not delivered
// - address registers hold last sector transferred, or the failing sector after an error
// - opcodes 20h/21h, low bit disables retries
// - uncorrectable error stops at failing sector
// - F8h returns true maximum, ignoring set-max limit
// - lba native maximum split like start address
// - chs native maximum gives top cylinder, head, sector
`timescale 1ns/1ps
`include "apr_defines.svh"
module apr_read_engine #(
  parameter int          WORDS_PER_SECTOR = `APR_WORDS_PER_SEC,
  parameter int          RETRIES          = `APR_RETRIES,
  parameter int          HEADS            = 16,
  parameter int          SECTORS_PER_TRK  = 63,
  parameter logic [27:0] NATIVE_MAX_LBA   = 28'h0FFFFFF,
  parameter logic [15:0] NATIVE_MAX_CYL   = 16'h3FFF,
  parameter logic        DRIVE_SEL        = 1'b0
) (
  // clock and reset
  input  logic                 sys_clk,
  input  logic                 reset_n,
  // axi4-lite write channels
  input  logic [7:0]           s_axi_awaddr,
  input  logic                 s_axi_awvalid,
  output logic                 s_axi_awready,
  input  logic [31:0]          s_axi_wdata,
  input  logic [3:0]           s_axi_wstrb,
  input  logic                 s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  logic                 s_axi_bready,
  // axi4-lite read channels
  input  logic [7:0]           s_axi_araddr,
  input  logic                 s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  logic                 s_axi_rready,
  // host interrupt
  output logic                 host_irq,
  // media request and answer
  output logic                 med_req_valid,
  output apr_pkg::apr_med_req_s med_req,
  input  logic                 med_rsp_valid,
  input  apr_pkg::apr_med_rsp_s med_rsp,
  // media sector words
  input  logic                 med_word_valid,
  input  logic [15:0]          med_word,
  output logic                 med_word_ready
);
  import apr_pkg::*;

  localparam int WCW = $clog2(WORDS_PER_SECTOR + 1);
  localparam int RCW = $clog2(RETRIES + 1);
  localparam logic [WCW-1:0] WORDS_LAST = WCW'(WORDS_PER_SECTOR);
  localparam logic [RCW-1:0] RETRY_INIT = RCW'(RETRIES);

  // axi holding state
  logic           aw_held_reg;
  logic           w_held_reg;
  logic [7:0]     awaddr_reg;
  logic [31:0]    wdata_reg;
  logic           wstrb0_reg;
  // task file
  apr_addr_s      tf_addr_reg;
  logic [3:0]     dh_hi_reg;
  logic [7:0]     count_reg;
  logic [7:0]     blksz_reg;
  logic [7:0]     error_reg;
  logic           err_flag_reg;
  logic           busy_reg;
  logic           irq_reg;
  // engine
  apr_state_e     state_reg;
  apr_addr_s      cur_addr_reg;
  logic           chs_reg;
  logic           retry_dis_reg;
  logic [8:0]     remain_reg;
  logic [7:0]     blk_len_reg;
  logic [7:0]     blk_left_reg;
  logic           blk_first_reg;
  logic [RCW-1:0] retry_reg;
  logic           req_valid_reg;
  // data path
  logic [15:0]    data_reg;
  logic           data_full_reg;
  logic [WCW-1:0] word_cnt_reg;
  logic           word_ready_reg;

  apr_addr_s      next_addr;
  logic           wr_fire;
  logic           rd_fire;
  logic           tf_we;
  logic           cmd_go;
  logic [7:0]     op;
  logic           op_read;
  logic           op_max;
  logic           op_abort;
  logic           rsp_err;
  logic           rsp_ok;
  logic           med_fail;
  logic           do_retry;
  logic           sect_done;
  logic           last_sect;
  logic           word_take;
  logic           pop;
  logic [31:0]    rd_val;

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a[1:0] == 2'b00) && (a <= `APR_OFS_BLKSZ);
  endfunction

  apr_addr_step #(
    .HEADS           (HEADS),
    .SECTORS_PER_TRK (SECTORS_PER_TRK)
  ) u_step (
    .cur (cur_addr_reg),
    .chs (chs_reg),
    .nxt (next_addr)
  );

  assign wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  // writes while busy are dropped so a running read keeps its set-up
  assign tf_we     = wr_fire && wstrb0_reg && !busy_reg;
  assign cmd_go    = tf_we && awaddr_reg == `APR_OFS_CMD &&
                     dh_hi_reg[`APR_DH_DRV - 4] == DRIVE_SEL;
  assign op        = wdata_reg[7:0];
  // block mode needs a configured block length
  assign op_read   = op == `APR_OP_READ || op == `APR_OP_READ_NR ||
                     (op == `APR_OP_BLOCK_READ && blksz_reg != 8'h00);
  assign op_max    = op == `APR_OP_NATIVE_MAX;
  assign op_abort  = cmd_go && !op_read && !op_max;
  assign rsp_err   = med_rsp.uncorrectable_cause || med_rsp.idnf || med_rsp.amnf;
  assign rsp_ok    = state_reg == ST_WAIT && med_rsp_valid && !rsp_err;
  assign do_retry  = !retry_dis_reg && retry_reg != '0;
  assign med_fail  = state_reg == ST_WAIT && med_rsp_valid && rsp_err &&
                     !do_retry;
  assign word_take = med_word_valid && word_ready_reg;
  assign pop       = rd_fire && s_axi_araddr == `APR_OFS_DATA &&
                     data_full_reg;
  assign sect_done = state_reg == ST_XFER && word_cnt_reg == WORDS_LAST &&
                     !data_full_reg;
  assign last_sect = remain_reg == 9'h001;

  // axi write address and data, taken in either order
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb0_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `APR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb0_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_mapped(awaddr_reg) ? `APR_RESP_OKAY :
                        `APR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read mux; lba bits 0-7, 8-15, 16-23, 24-27 sit in the fields
  always_comb begin
    rd_val = 32'h00000000;
    unique case (s_axi_araddr)
      `APR_OFS_DATA:   rd_val[15:0] = data_reg;
      `APR_OFS_ERROR:  rd_val[7:0]  = error_reg;
      `APR_OFS_COUNT:  rd_val[7:0]  = count_reg;
      `APR_OFS_SECTOR: rd_val[7:0]  = tf_addr_reg.sect;
      `APR_OFS_CYL_LO: rd_val[7:0]  = tf_addr_reg.cyl[7:0];
      `APR_OFS_CYL_HI: rd_val[7:0]  = tf_addr_reg.cyl[15:8];
      `APR_OFS_DRVHD:  rd_val[7:0]  = {dh_hi_reg, tf_addr_reg.head};
      `APR_OFS_CMD: begin
        rd_val[`APR_ST_BUSY] = busy_reg;
        rd_val[`APR_ST_RDY]  = 1'b1;
        rd_val[`APR_ST_DSC]  = 1'b1;
        rd_val[`APR_ST_DRQ]  = data_full_reg;
        rd_val[`APR_ST_ERR]  = err_flag_reg;
      end
      `APR_OFS_BLKSZ:  rd_val[7:0]  = blksz_reg;
      default:         rd_val       = 32'h00000000;
    endcase
  end

  // axi read channel
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `APR_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= reg_mapped(s_axi_araddr) ? `APR_RESP_OKAY :
                       `APR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // task file: host writes when idle, engine writes the outcome
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tf_addr_reg <= '0;
      dh_hi_reg   <= `APR_DH_FIXED;
      count_reg   <= 8'h00;
      blksz_reg   <= `APR_BLKSZ_RESET;
    end else begin
      if (tf_we) begin
        unique case (awaddr_reg)
          `APR_OFS_COUNT:  count_reg         <= wdata_reg[7:0];
          `APR_OFS_SECTOR: tf_addr_reg.sect  <= wdata_reg[7:0];
          `APR_OFS_CYL_LO: tf_addr_reg.cyl[7:0]  <= wdata_reg[7:0];
          `APR_OFS_CYL_HI: tf_addr_reg.cyl[15:8] <= wdata_reg[7:0];
          `APR_OFS_DRVHD: begin
            dh_hi_reg        <= wdata_reg[7:4];
            tf_addr_reg.head <= wdata_reg[3:0];
          end
          `APR_OFS_BLKSZ:  blksz_reg         <= wdata_reg[7:0];
          default: ;
        endcase
      end
      // true maximum, no set-max limit applies here
      if (cmd_go && op_max) begin
        if (dh_hi_reg[`APR_DH_LBA - 4]) begin
          tf_addr_reg <= apr_addr_s'(NATIVE_MAX_LBA);
        end else begin
          tf_addr_reg.sect <= 8'(SECTORS_PER_TRK);
          tf_addr_reg.cyl  <= NATIVE_MAX_CYL;
          tf_addr_reg.head <= 4'(HEADS - 1);
        end
      end
      if (sect_done && last_sect) begin
        tf_addr_reg <= cur_addr_reg;
        count_reg   <= 8'h00;
      end
      if (med_fail) begin
        tf_addr_reg <= cur_addr_reg;
        count_reg   <= remain_reg[7:0];
      end
    end
  end

  // busy, error flag and cause
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busy_reg     <= 1'b0;
      err_flag_reg <= 1'b0;
      error_reg    <= 8'h00;
    end else if (cmd_go) begin
      busy_reg     <= op_read;
      err_flag_reg <= op_abort;
      error_reg    <= 8'h00;
      error_reg[`APR_ER_ABT] <= op_abort;
    end else if (med_fail) begin
      busy_reg     <= 1'b0;
      err_flag_reg <= 1'b1;
      error_reg[`APR_ER_UNC] <= med_rsp.uncorrectable_cause;
      error_reg[`APR_ER_IDN] <= med_rsp.idnf;
      error_reg[`APR_ER_AMN] <= med_rsp.amnf;
    end else if (sect_done && last_sect) begin
      busy_reg     <= 1'b0;
    end
  end

  // command sequencing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      cur_addr_reg  <= '0;
      chs_reg       <= 1'b0;
      retry_dis_reg <= 1'b0;
      remain_reg    <= 9'h000;
      blk_len_reg   <= 8'h01;
      blk_left_reg  <= 8'h00;
      blk_first_reg <= 1'b0;
      retry_reg     <= '0;
      req_valid_reg <= 1'b0;
    end else begin
      req_valid_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: if (cmd_go && op_read) begin
          state_reg     <= ST_WAIT;
          req_valid_reg <= 1'b1;
          cur_addr_reg  <= tf_addr_reg;
          chs_reg       <= !dh_hi_reg[`APR_DH_LBA - 4];
          retry_dis_reg <= op[0];
          retry_reg     <= RETRY_INIT;
          remain_reg    <= count_reg == 8'h00 ? `APR_ZERO_COUNT :
                           {1'b0, count_reg};
          blk_len_reg   <= op == `APR_OP_BLOCK_READ ? blksz_reg : 8'h01;
          blk_left_reg  <= 8'h00;
        end
        ST_WAIT: if (med_rsp_valid) begin
          if (!rsp_err) begin
            state_reg     <= ST_XFER;
            blk_first_reg <= blk_left_reg == 8'h00;
            blk_left_reg  <= blk_left_reg == 8'h00 ?
                             blk_len_reg - 8'h01 : blk_left_reg - 8'h01;
          end else if (do_retry) begin
            retry_reg     <= retry_reg - RCW'(1);
            req_valid_reg <= 1'b1;
          end else begin
            state_reg     <= ST_IDLE;
          end
        end
        ST_XFER: if (sect_done) begin
          if (last_sect) begin
            state_reg     <= ST_IDLE;
          end else begin
            state_reg     <= ST_WAIT;
            req_valid_reg <= 1'b1;
            cur_addr_reg  <= next_addr;
            retry_reg     <= RETRY_INIT;
          end
          remain_reg <= remain_reg - 9'h001;
        end
      endcase
    end
  end

  // one-word holding register toward the host
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      data_reg       <= 16'h0000;
      data_full_reg  <= 1'b0;
      word_cnt_reg   <= '0;
      word_ready_reg <= 1'b0;
    end else begin
      if (word_take) begin
        data_reg <= med_word;
      end
      data_full_reg <= word_take || (data_full_reg && !pop);
      if (rsp_ok) begin
        word_cnt_reg <= '0;
      end else if (word_take) begin
        word_cnt_reg <= word_cnt_reg + WCW'(1);
      end
      // ready looks one word ahead so the sector never overruns
      word_ready_reg <= state_reg == ST_XFER && !rsp_ok &&
                        !(word_take || (data_full_reg && !pop)) &&
                        (word_cnt_reg + WCW'(word_take)) < WORDS_LAST;
    end
  end

  // interrupt: block start, error end, non-data end; read of status clears
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (word_take && word_cnt_reg == '0 && blk_first_reg) ||
                 (cmd_go && !op_read) || med_fail ||
                 (irq_reg && !(rd_fire &&
                   s_axi_araddr == `APR_OFS_CMD));
    end
  end

  assign host_irq       = irq_reg;
  assign med_req_valid  = req_valid_reg;
  assign med_req        = '{addr: cur_addr_reg, chs: chs_reg,
                            retry_dis: retry_dis_reg};
  assign med_word_ready = word_ready_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_start_issue: assert property (cmd_go && op_read |=>
    busy_reg && med_req_valid && cur_addr_reg == $past(tf_addr_reg))
    else $error("read command did not start");
  a_word_pop: assert property (pop |=>
    s_axi_rdata == {16'h0000, $past(data_reg)})
    else $error("data port word wrong");
  a_block_irq: assert property (word_take && word_cnt_reg == '0 &&
    blk_first_reg |=> host_irq)
    else $error("no interrupt at block start");
  a_zero_count: assert property (cmd_go && op_read &&
    count_reg == 8'h00 |=> remain_reg == 9'h100)
    else $error("zero count not taken as 256");
  a_done_regs: assert property (sect_done && last_sect |=>
    tf_addr_reg == $past(cur_addr_reg) && count_reg == 8'h00 &&
    !busy_reg && !err_flag_reg)
    else $error("completion registers wrong");
  a_fail_regs: assert property (med_fail |=>
    count_reg == $past(remain_reg[7:0]) && err_flag_reg &&
    error_reg[`APR_ER_UNC] == $past(med_rsp.uncorrectable_cause) && !busy_reg)
    else $error("error completion wrong");
  a_no_retry: assert property (state_reg == ST_WAIT &&
    med_rsp_valid && rsp_err && retry_dis_reg |=> state_reg == ST_IDLE
    && !med_req_valid)
    else $error("retry despite retry disable");
  a_fail_stops: assert property (med_fail |=>
    tf_addr_reg == $past(cur_addr_reg) ##1 !med_req_valid[*2])
    else $error("transfer went on after failure");
  a_native_lba: assert property (cmd_go && op_max &&
    dh_hi_reg[`APR_DH_LBA - 4] |=> tf_addr_reg == NATIVE_MAX_LBA && !busy_reg)
    else $error("native maximum lba wrong");
  a_native_chs: assert property (cmd_go && op_max &&
    !dh_hi_reg[`APR_DH_LBA - 4] |=> tf_addr_reg.cyl == NATIVE_MAX_CYL)
    else $error("native maximum chs wrong");
  a_abort_flags: assert property (op_abort |=>
    error_reg[`APR_ER_ABT] && err_flag_reg && !busy_reg &&
    state_reg == ST_IDLE)
    else $error("abort not reported");

  c_block_read: cover property (cmd_go && op == `APR_OP_BLOCK_READ
    && op_read ##[1:1000] sect_done);
  c_media_fail: cover property (med_fail);
  c_native_max: cover property (cmd_go && op_max);

endmodule

// File: tb/apr_media_model.sv
/*
  Media stand-in for the read engine: answers each sector request after
  a short or a longer wait, then, unless it answers with a fault, offers the sector's words.
  Assumes the engine's valid/ready handshakes on sys_clk.
*/
`timescale 1ns/1ps
module apr_media_model #(
  parameter int WORDS = 4
) (
  // clock
  input  wire logic                  sys_clk,
  // request and answer
  input  wire logic                  med_req_valid,
  input  wire apr_pkg::apr_med_req_s med_req,
  output apr_pkg::apr_med_rsp_s      med_rsp,
  output logic                       med_rsp_valid,
  // sector words
  output logic                       med_word_valid,
  output logic [15:0]                med_word,
  input  wire logic                  med_word_ready,
  // fault control
  input  wire apr_pkg::apr_med_rsp_s fail_rsp,
  input  wire logic [7:0]            fail_sect
);
  import apr_pkg::*;
  apr_med_req_s req;
  int           left = 0;
  int           idx = 0;
  int           dly = -1;
  logic         bad;
  initial begin
    med_rsp_valid = 1'b0;
    med_rsp = '0;
    med_word_valid = 1'b0;
    med_word = 16'h0000;
  end
  always @(posedge sys_clk) begin
    med_rsp_valid <= 1'b0;
    if (med_word_valid && med_word_ready) begin
      idx++;
      left--;
    end
    if (med_req_valid) begin
      req = med_req;
      // odd sectors answer at once, even ones late
      dly = med_req.addr.sect[0] ? 0 : 3;
    end else if (dly > 0) begin
      dly--;
    end else if (dly == 0) begin
      dly = -1;
      bad = fail_rsp != '0 && (req.addr.sect == fail_sect);
      med_rsp_valid <= 1'b1;
      med_rsp <= bad ? fail_rsp : '0;
      left = bad ? 0 : WORDS;
      idx = 0;
    end
    med_word_valid <= (left > 0);
    // idle word toggles so a stale value is never mistaken for data
    med_word <= (left > 0) ? {req.addr.sect, idx[7:0]} : ~med_word;
  end
endmodule

// File: tb/test_apr_read_engine.sv
/*
  Bench for apr_read_engine: axi4-lite host tasks, media model on the far
  side, sectors shortened to four words.
  Assumes the engine's register map and status bits from its defines.
*/
`timescale 1ns/1ps
`include "apr_defines.svh"
module test_apr_read_engine;
  import apr_pkg::*;
  localparam int W = 4;
  logic sys_clk = 0, reset_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, fail_sect = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, host_irq, med_req_valid, med_rsp_valid;
  logic med_word_valid, med_word_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [15:0] med_word;
  apr_med_req_s med_req, last_req;
  apr_med_rsp_s med_rsp, fail_rsp = '0;
  int n_errors = 0, total_checks = 0, n_irq = 0, n_req = 0;
  int nw, dr, di;
  logic [31:0] d;
  // abort cases: read-multiple with block mode off, unknown opcode
  logic [7:0] dr_ops [2] = '{`APR_OP_BLOCK_READ, 8'h30};
  apr_read_engine #(.WORDS_PER_SECTOR(W)) dut (
    .sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .host_irq, .med_req_valid, .med_req, .med_rsp_valid,
    .med_rsp, .med_word_valid, .med_word, .med_word_ready);
  apr_media_model #(.WORDS(W)) media (
    .sys_clk, .med_req_valid, .med_req, .med_rsp, .med_rsp_valid,
    .med_word_valid, .med_word, .med_word_ready, .fail_rsp, .fail_sect);
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if ($rose(host_irq)) n_irq++;
    if (med_req_valid) begin
      n_req++;
      last_req <= med_req;
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bound(input bit hit);
    if (hit) begin
      n_errors++;
      complete_run();
    end
  endtask
  // bready held from the start; the b edge is where bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 20000);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    bound(n >= 20000);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 20000);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n >= 20000);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // load the task file, issue op, pop words while status shows one
  task automatic go(input logic [7:0] c, s, l, h, dh, op, input bit full);
    logic [31:0] v;
    int n;
    dr = n_req;
    di = n_irq;
    nw = 0;
    wr(`APR_OFS_COUNT, c);
    wr(`APR_OFS_SECTOR, s);
    wr(`APR_OFS_CYL_LO, l);
    wr(`APR_OFS_CYL_HI, h);
    wr(`APR_OFS_DRVHD, dh);
    wr(`APR_OFS_CMD, op);
    // bounded so a stuck busy cannot run the bench past its cycle budget
    for (n = 0; n < 4000; n++) begin
      rd(`APR_OFS_CMD, v);
      if (v[`APR_ST_DRQ]) begin
        rd(`APR_OFS_DATA, v);
        chk(v[7:0], 8'(nw % W));
        if (full) chk(v[15:8], 8'(s + nw / W));
        nw++;
      end else if (!v[`APR_ST_BUSY]) break;
    end
    bound(n >= 4000);
    dr = n_req - dr;
    di = n_irq - di;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rc(`APR_OFS_CMD, 32'h50);
    rc(`APR_OFS_DRVHD, 32'hA0);
    rc(8'h24, 32'h0);
    chk(last_resp, `APR_RESP_SLVERR);
    wr(8'h24, 8'h00);
    chk(last_resp, `APR_RESP_SLVERR);
    go(8'h02, 8'h10, 8'h34, 8'h12, 8'hE5, `APR_OP_READ, 1);
    chk(nw, 8);
    chk(di, 2);
    chk(last_req, {28'h5123411, 2'b00});
    rc(`APR_OFS_COUNT, 32'h0);
    rc(`APR_OFS_SECTOR, 32'h11);
    rc(`APR_OFS_CMD, 32'h50);
    go(8'h02, 8'h3F, 8'h00, 8'h00, 8'hA0, `APR_OP_READ_NR, 0);
    chk(last_req, {28'h1000001, 2'b11});
    rc(`APR_OFS_SECTOR, 32'h01);
    @(posedge sys_clk);
    fail_sect <= 8'h11;
    fail_rsp <= 3'b100;
    go(8'h03, 8'h10, 8'h00, 8'h00, 8'hE0, `APR_OP_READ_NR, 1);
    chk(nw, 4);
    chk(dr, 2);
    rc(`APR_OFS_ERROR, 32'h40);
    rc(`APR_OFS_COUNT, 32'h02);
    rc(`APR_OFS_SECTOR, 32'h11);
    rc(`APR_OFS_CMD, 32'h51);
    fail_rsp <= 3'b011;
    go(8'h03, 8'h10, 8'h00, 8'h00, 8'hE0, `APR_OP_READ, 1);
    chk(dr, 2 + `APR_RETRIES);
    rc(`APR_OFS_ERROR, 32'h11);
    fail_rsp <= '0;
    foreach (dr_ops[k]) begin
      go(8'h01, 8'h00, 8'h00, 8'h00, 8'hE0, dr_ops[k], 0);
      chk(nw, 0);
      rc(`APR_OFS_ERROR, 32'h04);
    end
    go(8'h01, 8'h00, 8'h00, 8'h00, 8'hB0, `APR_OP_READ, 0);
    chk(dr, 0);
    wr(`APR_OFS_BLKSZ, 8'h02);
    go(8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, `APR_OP_BLOCK_READ, 1);
    chk(nw, 256 * W);
    chk(di, 128);
    rc(`APR_OFS_SECTOR, 32'hFF);
    go(8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, `APR_OP_NATIVE_MAX, 0);
    rc(`APR_OFS_SECTOR, 32'hFF);
    rc(`APR_OFS_CYL_HI, 32'hFF);
    go(8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, `APR_OP_NATIVE_MAX, 0);
    rc(`APR_OFS_SECTOR, 32'h3F);
    rc(`APR_OFS_CYL_HI, 32'h3F);
    rd(`APR_OFS_DRVHD, d);
    chk(d[3:0], 4'hF);
    complete_run();
  end
endmodule
